// *** fsb_status_bus.sv ***
// Fault status bus transmitter, command receiver and error flag logic
`timescale 1ns/10ps
`include "fsb_defines.svh"

// ----------------------------------------------------------------------
// Status word FIFO
// ----------------------------------------------------------------------
module fsb_fifo #(
    parameter int WIDTH = `FSB_WORD_W,
    parameter int DEPTH = `FSB_FIFO_DEPTH
) (
    input  wire logic             mclk,
    input  wire logic             rst_n,
    input  wire logic             flush,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH)
            $error("fsb_fifo: DEPTH must be a power of two >= 2");
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic [AW:0]      next_wr_ptr;
    logic [AW:0]      next_rd_ptr;
    logic             push;
    logic             pop;

    assign in_ready  = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
    assign out_valid = wr_ptr != rd_ptr;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        if (flush) begin
            next_rd_ptr = wr_ptr;
        end else begin
            if (push)
                next_wr_ptr = wr_ptr + (AW+1)'(1);
            if (pop)
                next_rd_ptr = rd_ptr + (AW+1)'(1);
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr   <= '0;
            rd_ptr   <= '0;
            out_data <= '0;
        end else begin
            wr_ptr   <= next_wr_ptr;
            rd_ptr   <= next_rd_ptr;
            // Bypass a word written into the slot about to be shown
            out_data <= (push && !flush && next_rd_ptr == wr_ptr)
                        ? in_data : mem[next_rd_ptr[AW-1:0]];
        end
    end

    always_ff @(posedge mclk) begin
        if (push && !flush)
            mem[wr_ptr[AW-1:0]] <= in_data;
    end
endmodule // fsb_fifo

module fsb_status_bus #(
    parameter int FIFO_DEPTH = `FSB_FIFO_DEPTH
) (
    input  wire logic                     mclk,
    input  wire logic                     rst_n,
    input  wire logic                     power_up_done,
    input  wire logic [`FSB_ID_SEL_W-1:0] id_strap,
    input  wire logic [`FSB_WORD_W-1:0]   fault_status,
    input  wire logic                     ls_shutdown_only,
    input  wire logic                     status_line_in,
    output logic                          status_line_out,
    output logic                          status_line_oe,
    input  wire logic                     overvoltage_trip,
    input  wire logic                     overvoltage_release,
    input  wire logic                     over_temp_shutdown,
    input  wire logic                     over_temp_restart,
    input  wire logic                     hysteretic_temp_cfg,
    input  wire logic                     sustained_over_current,
    input  wire logic                     latching_oc_cfg,
    input  wire logic                     error_flag_line_in,
    output logic                          error_flag_line_out,
    output logic                          error_flag_line_oe,
    output logic                          switching_inhibit,
    output logic                          power_up_request,
    output logic                          update_dropped
);
    import fsb_pkg::*;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam fsb_cnt_t BIT_LOW_CYC  = `FSB_CYC(`FSB_BIT_LOW_US);
    localparam fsb_cnt_t ONE_CYC      = `FSB_CYC(`FSB_ONE_HIGH_US);
    localparam fsb_cnt_t ZERO_CYC     = `FSB_CYC(`FSB_ZERO_HIGH_US);
    localparam fsb_cnt_t STEADY_CYC   = `FSB_CYC(`FSB_STEADY_US);
    localparam fsb_cnt_t IDLE_CYC     = `FSB_CYC(`FSB_IDLE_US);
    localparam fsb_cnt_t QUERY_CYC    = `FSB_CYC(`FSB_QUERY_US);
    localparam fsb_cnt_t LCLR_CYC     = `FSB_CYC(`FSB_LATCH_CLR_US);
    localparam fsb_cnt_t TOL_CYC      = `FSB_CYC(`FSB_TOL_US);
    localparam fsb_cnt_t INHIBIT_CYC  = `FSB_CYC(`FSB_INHIBIT_US);
    localparam fsb_cnt_t CHECK_CYC    = BIT_LOW_CYC;

    initial begin
        if (FIFO_DEPTH < 2)
            $error("fsb_status_bus: FIFO_DEPTH too small");
    end

    function automatic logic odd_parity(input logic [`FSB_WORD_W-1:0] w);
        return ~(^w);
    endfunction

    // ------------------------------------------------------------------
    // Power-up capture and mission mode
    // ------------------------------------------------------------------
    logic     mission;
    logic     next_mission;
    fsb_cnt_t id_cyc;
    fsb_cnt_t next_id_cyc;
    logic     latch_reset_cmd;
    logic     query_cmd;

    always_comb begin
        next_mission = mission;
        next_id_cyc  = id_cyc;
        if (latch_reset_cmd) begin
            next_mission = 1'b0;
        end else if (power_up_done && !mission) begin
            next_mission = 1'b1;
            unique case (id_strap)
                `FSB_ID_SEL_1: next_id_cyc = `FSB_CYC(`FSB_ID1_US);
                `FSB_ID_SEL_2: next_id_cyc = `FSB_CYC(`FSB_ID2_US);
                default:       next_id_cyc = `FSB_CYC(`FSB_ID3_US);
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mission <= 1'b0;
            id_cyc  <= `FSB_CYC(`FSB_ID3_US);
        end else begin
            mission <= next_mission;
            id_cyc  <= next_id_cyc;
        end
    end

    // ------------------------------------------------------------------
    // Change detection into the FIFO
    // ------------------------------------------------------------------
    logic [`FSB_WORD_W-1:0] last_status;
    logic [`FSB_WORD_W-1:0] next_last_status;
    logic [`FSB_WORD_W-1:0] push_word;
    logic                   push_valid;
    logic                   push_ready;
    logic                   ready_pending;
    logic                   next_ready_pending;
    logic                   query_pending;
    logic                   next_query_pending;
    logic                   changed;

    assign changed = (fault_status != last_status) && !ls_shutdown_only;

    always_comb begin
        next_last_status   = last_status;
        next_ready_pending = ready_pending;
        next_query_pending = query_pending;
        push_valid         = 1'b0;
        push_word          = fault_status;
        if (query_cmd)
            next_query_pending = 1'b1;
        if (latch_reset_cmd) begin
            next_last_status   = '0;
            next_ready_pending = 1'b1;
            next_query_pending = 1'b0;
        end else if (mission) begin
            if (ready_pending) begin
                push_valid = 1'b1;
                push_word  = '0;
                if (push_ready)
                    next_ready_pending = 1'b0;
            end else if (changed || query_pending) begin
                push_valid = 1'b1;
                if (push_ready) begin
                    next_last_status   = fault_status;
                    next_query_pending = query_cmd;
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            last_status   <= '0;
            ready_pending <= 1'b1;
            query_pending <= 1'b0;
            update_dropped <= 1'b0;
        end else begin
            last_status   <= next_last_status;
            ready_pending <= next_ready_pending;
            query_pending <= next_query_pending;
            update_dropped <= push_valid && !push_ready;
        end
    end

    logic                   pop_valid;
    logic                   pop_ready;
    logic [`FSB_WORD_W-1:0] pop_word;

    fsb_fifo #(
        .WIDTH (`FSB_WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .flush     (latch_reset_cmd),
        .in_valid  (push_valid),
        .in_ready  (push_ready),
        .in_data   (push_word),
        .out_valid (pop_valid),
        .out_ready (pop_ready),
        .out_data  (pop_word)
    );

    // ------------------------------------------------------------------
    // Transmitter
    // ------------------------------------------------------------------
    fsb_tx_e                 state;
    fsb_tx_e                 next_state;
    fsb_cnt_t                cnt;
    fsb_cnt_t                next_cnt;
    logic [`FSB_FRAME_W-1:0] frame;
    logic [`FSB_FRAME_W-1:0] next_frame;
    logic [3:0]              bit_idx;
    logic [3:0]              next_bit_idx;
    logic                    drive_low;
    logic                    next_drive_low;

    always_comb begin
        next_state     = state;
        next_cnt       = cnt + 32'h1;
        next_frame     = frame;
        next_bit_idx   = bit_idx;
        next_drive_low = 1'b0;
        pop_ready      = 1'b0;
        unique case (state)
            FSB_IDLE_WAIT: begin
                if (!status_line_in)
                    next_cnt = '0;
                else if (cnt >= STEADY_CYC && pop_valid && mission) begin
                    pop_ready      = 1'b1;
                    next_frame     = {odd_parity(pop_word), pop_word};
                    next_state     = FSB_ARB_LOW;
                    next_cnt       = '0;
                    next_drive_low = 1'b1;
                end
            end
            FSB_ARB_LOW: begin
                next_drive_low = 1'b1;
                if (cnt >= id_cyc - 32'h1) begin
                    next_drive_low = 1'b0;
                    next_state     = FSB_ARB_CHECK;
                    next_cnt       = '0;
                end
            end
            FSB_ARB_CHECK: begin
                if (cnt >= 32'h1 && !status_line_in) begin
                    next_state = FSB_IDLE_WAIT;
                    next_cnt   = '0;
                end else if (cnt >= CHECK_CYC) begin
                    next_state   = FSB_BIT_HIGH;
                    next_cnt     = '0;
                    next_bit_idx = '0;
                end
            end
            FSB_BIT_HIGH: begin
                if (cnt >= (frame[bit_idx[2:0]] ? ONE_CYC : ZERO_CYC)
                        - 32'h1) begin
                    next_state     = FSB_BIT_LOW;
                    next_cnt       = '0;
                    next_drive_low = 1'b1;
                end
            end
            FSB_BIT_LOW: begin
                next_drive_low = 1'b1;
                if (cnt >= BIT_LOW_CYC - 32'h1) begin
                    next_drive_low = 1'b0;
                    next_cnt       = '0;
                    if (bit_idx == 4'(`FSB_FRAME_W - 1)) begin
                        next_state = FSB_HOLDOFF;
                    end else begin
                        next_bit_idx = bit_idx + 4'h1;
                        next_state   = FSB_BIT_HIGH;
                    end
                end
            end
            FSB_HOLDOFF: begin
                if (cnt >= IDLE_CYC - 32'h1) begin
                    next_state = FSB_IDLE_WAIT;
                    next_cnt   = STEADY_CYC;
                end
            end
            default: begin
                next_state = FSB_IDLE_WAIT;
                next_cnt   = '0;
            end
        endcase
        if (latch_reset_cmd) begin
            next_state     = FSB_IDLE_WAIT;
            next_cnt       = '0;
            next_drive_low = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state     <= FSB_IDLE_WAIT;
            cnt       <= '0;
            frame     <= '0;
            bit_idx   <= '0;
            drive_low <= 1'b0;
        end else begin
            state     <= next_state;
            cnt       <= next_cnt;
            frame     <= next_frame;
            bit_idx   <= next_bit_idx;
            drive_low <= next_drive_low;
        end
    end

    assign status_line_out = 1'b0;
    assign status_line_oe  = drive_low;

    // ------------------------------------------------------------------
    // Command receiver: measures foreign low pulses
    // ------------------------------------------------------------------
    fsb_cnt_t low_cnt;
    fsb_cnt_t next_low_cnt;
    logic     line_prev;

    always_comb begin
        next_low_cnt    = low_cnt;
        query_cmd       = 1'b0;
        latch_reset_cmd = 1'b0;
        if (!status_line_in && !drive_low) begin
            if (low_cnt != 32'hFFFFFFFF)
                next_low_cnt = low_cnt + 32'h1;
        end else begin
            next_low_cnt = '0;
            if (!line_prev && mission && low_cnt != 32'h0) begin
                if (low_cnt >= QUERY_CYC - TOL_CYC
                        && low_cnt <= QUERY_CYC + TOL_CYC)
                    query_cmd = 1'b1;
                else if (low_cnt >= LCLR_CYC - TOL_CYC
                        && low_cnt <= LCLR_CYC + TOL_CYC)
                    latch_reset_cmd = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            low_cnt   <= '0;
            line_prev <= 1'b1;
        end else begin
            low_cnt   <= next_low_cnt;
            line_prev <= status_line_in || drive_low;
        end
    end

    assign power_up_request = latch_reset_cmd;

    // ------------------------------------------------------------------
    // Error flag
    // ------------------------------------------------------------------
    logic     ov_flag;
    logic     ot_flag;
    logic     oc_flag;
    logic     ef_prev;
    logic     ef_rise;
    logic     next_ov_flag;
    logic     next_ot_flag;
    logic     next_oc_flag;
    fsb_cnt_t inh_cnt;
    fsb_cnt_t next_inh_cnt;
    logic     next_inhibit;

    assign ef_rise = error_flag_line_in && !ef_prev;

    always_comb begin
        next_ov_flag = ov_flag;
        if (overvoltage_trip)
            next_ov_flag = 1'b1;
        else if (overvoltage_release)
            next_ov_flag = 1'b0;
        next_ot_flag = ot_flag;
        if (over_temp_shutdown)
            next_ot_flag = 1'b1;
        else if (ef_rise || latch_reset_cmd
                || (hysteretic_temp_cfg && over_temp_restart))
            next_ot_flag = 1'b0;
        next_oc_flag = oc_flag;
        if (sustained_over_current && latching_oc_cfg)
            next_oc_flag = 1'b1;
        else if (ef_rise || latch_reset_cmd)
            next_oc_flag = 1'b0;
        next_inh_cnt = '0;
        next_inhibit = 1'b0;
        if (!error_flag_line_in) begin
            next_inh_cnt = inh_cnt;
            if (inh_cnt >= INHIBIT_CYC - 32'h1)
                next_inhibit = 1'b1;
            else
                next_inh_cnt = inh_cnt + 32'h1;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ov_flag           <= 1'b0;
            ot_flag           <= 1'b0;
            oc_flag           <= 1'b0;
            ef_prev           <= 1'b1;
            inh_cnt           <= '0;
            switching_inhibit <= 1'b0;
        end else begin
            ov_flag           <= next_ov_flag;
            ot_flag           <= next_ot_flag;
            oc_flag           <= next_oc_flag;
            ef_prev           <= error_flag_line_in;
            inh_cnt           <= next_inh_cnt;
            switching_inhibit <= next_inhibit;
        end
    end

    assign error_flag_line_out = 1'b0;
    assign error_flag_line_oe  = ov_flag || ot_flag || oc_flag;
endmodule // fsb_status_bus

// *** fsb_defines.svh ***
// Timing constants and field positions for the fault status bus block
`ifndef FSB_DEFINES_SVH
`define FSB_DEFINES_SVH

// ----------------------------------------------------------------------
// Clock
// ----------------------------------------------------------------------
`define FSB_CLK_KHZ          40000
// ----------------------------------------------------------------------
// Times in microseconds
// ----------------------------------------------------------------------
`define FSB_BIT_LOW_US       10
`define FSB_ONE_HIGH_US      40
`define FSB_ZERO_HIGH_US     10
`define FSB_STEADY_US        80
`define FSB_IDLE_US          160
`define FSB_QUERY_US         160
`define FSB_LATCH_CLR_US     320
`define FSB_ID1_US           40
`define FSB_ID2_US           60
`define FSB_ID3_US           80
`define FSB_TOL_US           40
`define FSB_INHIBIT_US       2
// ----------------------------------------------------------------------
// Cycle counts derived from the clock
// ----------------------------------------------------------------------
`define FSB_CYC(us)          (((us) * `FSB_CLK_KHZ) / 1000)
// ----------------------------------------------------------------------
// Status word layout
// ----------------------------------------------------------------------
`define FSB_WORD_W           7
`define FSB_FRAME_W          8
`define FSB_ID_SEL_W         2
`define FSB_ID_SEL_1         2'h0
`define FSB_ID_SEL_2         2'h1
`define FSB_ID_SEL_3         2'h2
`define FSB_FIFO_DEPTH       16

`endif

// *** fsb_pkg.sv ***
// Types shared by the fault status bus block
package fsb_pkg;
    typedef enum logic [2:0] {
        FSB_IDLE_WAIT = 3'h0,
        FSB_ARB_LOW   = 3'h1,
        FSB_ARB_CHECK = 3'h2,
        FSB_BIT_HIGH  = 3'h3,
        FSB_BIT_LOW   = 3'h4,
        FSB_HOLDOFF   = 3'h5
    } fsb_tx_e;
    typedef logic [31:0] fsb_cnt_t;
endpackage

// *** fsb_status_bus_properties.sv ***
// Port assertions for the fault status bus block
`timescale 1ns/10ps
module fsb_status_bus_properties (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic status_line_in,
    input wire logic status_line_oe,
    input wire logic overvoltage_trip,
    input wire logic overvoltage_release,
    input wire logic over_temp_shutdown,
    input wire logic sustained_over_current,
    input wire logic latching_oc_cfg,
    input wire logic error_flag_line_in,
    input wire logic error_flag_line_oe,
    input wire logic switching_inhibit,
    input wire logic power_up_request
);
    int   hi;
    int   on;
    int   lo;
    logic set_in;
    assign set_in = overvoltage_trip || over_temp_shutdown ||
                    (sustained_over_current && latching_oc_cfg);
    // Run lengths of the status wire high, own drive and flag wire low
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            hi <= 0;
            on <= 0;
            lo <= 0;
        end else begin
            hi <= status_line_in ? hi + 1 : 0;
            on <= status_line_oe ? on + 1 : 0;
            lo <= error_flag_line_in ? 0 : lo + 1;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    chk_idle_gap: assert property ($rose(status_line_oe) |-> hi > 3198 ||
        hi inside {[397:403], [797:803], [1597:1603], [1997:2003]})
        else $error("drive began after a bad high time");
    chk_pulse_len: assert property ($fell(status_line_oe) |->
        on inside {[398:402], [1598:1602], [2398:2402], [3198:3202]})
        else $error("low drive has a bad length");
    chk_ov_set: assert property (
        overvoltage_trip |-> ##[1:2] error_flag_line_oe)
        else $error("overvoltage not flagged");
    chk_ot_set: assert property (
        over_temp_shutdown |-> ##[1:2] error_flag_line_oe)
        else $error("over temperature not flagged");
    chk_flag_cause: assert property ($rose(error_flag_line_oe) |->
        $past(set_in) || $past(set_in, 2))
        else $error("flag raised without a fault");
    chk_flag_clear: assert property ($rose(error_flag_line_in) &&
        !set_in && overvoltage_release |-> ##[1:3] !error_flag_line_oe)
        else $error("flag rise did not clear latches");
    chk_inhibit_wait: assert property (
        lo inside {[1:70]} |-> !switching_inhibit)
        else $error("inhibit came too early");
    chk_inhibit_on: assert property (lo > 90 |-> switching_inhibit)
        else $error("inhibit missing");
    chk_inhibit_off: assert property (
        error_flag_line_in [*2] |-> !switching_inhibit)
        else $error("inhibit held after flag rise");
    chk_request_pulse: assert property (
        power_up_request |=> !power_up_request)
        else $error("power up request too long");
    cover property ($rose(status_line_oe) && hi > 3198);
    cover property (power_up_request);
    cover property (switching_inhibit);
endmodule // fsb_status_bus_properties

bind fsb_status_bus fsb_status_bus_properties i_chk (.*);

// *** fsb_mcu_model.sv ***
// Controller on the status wire: sends commands, decodes frames
`timescale 1ns/10ps
module fsb_mcu_model (
    input  wire logic mclk,
    input  wire logic rst_n,
    input  wire logic dut_oe,
    output logic      line
);
    logic [7:0] frames[$];
    logic       mcu_lo = 1'b0;
    logic       prev   = 1'b1;
    logic       in_frm = 1'b0;
    logic       first  = 1'b0;
    logic [6:0] sh     = 7'h00;
    logic       b;
    int         hlen   = 0;
    int         llen   = 0;
    int         nb     = 0;
    // Pull-up: the wire is high unless someone sinks it
    assign line = !(dut_oe || mcu_lo);
    task automatic cmd_low(input int n);
        @(posedge mclk);
        mcu_lo <= 1'b1;
        repeat (n) @(posedge mclk);
        mcu_lo <= 1'b0;
    endtask
    always @(posedge mclk) begin
        prev <= line;
        hlen <= line ? (prev ? hlen + 1 : 1) : hlen;
        llen <= line ? llen : (prev ? 1 : llen + 1);
        b = hlen > (first ? 1400 : 1000);
        if (!rst_n) begin
            in_frm <= 1'b0;
        end else if (line && !prev && llen > 1000) begin
            in_frm <= 1'b1;
            first <= 1'b1;
            nb <= 0;
        end else if (line && !prev && in_frm) begin
            first <= 1'b0;
            nb <= nb + 1;
            if (nb == 7) begin
                frames.push_back({b, sh});
                in_frm <= 1'b0;
            end else begin
                sh[nb] <= b;
            end
        end
    end
endmodule // fsb_mcu_model

// *** fsb_status_bus_test.sv ***
// Self-checking bench for the fault status bus block
`timescale 1ns/10ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin err_total++; \
    $display("Error %s expected %0h seen %0h", n, e, g); end end
module fsb_status_bus_test;
    logic       mclk     = 1'b0;
    logic       rst_n    = 1'b0;
    logic       pwr_done = 1'b0;
    logic [6:0] fault    = 7'h00;
    logic       ov_trip  = 1'b0;
    logic       ov_rel   = 1'b1;
    logic       ot_sd    = 1'b0;
    logic       soc      = 1'b0;
    logic       loc      = 1'b0;
    logic       ext_hi   = 1'b0;
    logic       pur_seen = 1'b0;
    logic [1:0] strap    = 2'h0;
    logic       ls       = 1'b0;
    logic       ot_rs    = 1'b0;
    logic       hyst     = 1'b0;
    logic       drop_seen = 1'b0;
    logic       st_line, st_oe, ef_oe, inhibit, pur, drop;
    int         err_total = 0;
    int         n_tests   = 0;
    wire        ef_line = ext_hi | !ef_oe;
    fsb_status_bus i_dut (
        .mclk(mclk), .rst_n(rst_n), .power_up_done(pwr_done),
        .id_strap(strap), .fault_status(fault), .ls_shutdown_only(ls),
        .status_line_in(st_line), .status_line_out(), .status_line_oe(st_oe),
        .overvoltage_trip(ov_trip), .overvoltage_release(ov_rel),
        .over_temp_shutdown(ot_sd), .over_temp_restart(ot_rs),
        .hysteretic_temp_cfg(hyst), .sustained_over_current(soc),
        .latching_oc_cfg(loc), .error_flag_line_in(ef_line),
        .error_flag_line_out(), .error_flag_line_oe(ef_oe),
        .switching_inhibit(inhibit), .power_up_request(pur),
        .update_dropped(drop)
    );
    fsb_mcu_model i_mcu (.mclk(mclk), .rst_n(rst_n), .dut_oe(st_oe),
        .line(st_line));
    always #12.5 mclk = ~mclk;
    always @(posedge mclk) if (pur) pur_seen <= 1'b1;
    always @(posedge mclk) if (drop) drop_seen <= 1'b1;
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic wait_chk(input int n, input string nm, input logic e,
                            ref logic g);
        cyc(n);
        @(negedge mclk);
        `CHK(nm, e, g)
    endtask
    task automatic wait_frame(input string nm, input logic [7:0] e);
        int         k   = 0;
        logic [7:0] got = 8'hXX;
        while (i_mcu.frames.size() == 0 && k < 40000) begin
            cyc(1);
            k++;
        end
        if (i_mcu.frames.size() > 0) got = i_mcu.frames.pop_front();
        `CHK(nm, e, got)
    endtask
    task automatic t_flag;
        cyc(1);
        ov_rel <= 1'b0;
        ov_trip <= 1'b1;
        wait_chk(3, "ov flag", 1'b1, ef_oe);
        wait_chk(95, "inhibit", 1'b1, inhibit);
        cyc(1);
        ov_trip <= 1'b0;
        wait_chk(3, "ov hyst", 1'b1, ef_oe);
        cyc(1);
        ov_rel <= 1'b1;
        wait_chk(3, "ov clear", 1'b0, ef_oe);
        wait_chk(3, "inhibit off", 1'b0, inhibit);
        cyc(1);
        ot_sd <= 1'b1;
        cyc(1);
        ot_sd <= 1'b0;
        wait_chk(20, "ot latch", 1'b1, ef_oe);
        cyc(1);
        ext_hi <= 1'b1;
        wait_chk(4, "ot clear", 1'b0, ef_oe);
        cyc(1);
        ext_hi <= 1'b0;
        soc <= 1'b1;
        wait_chk(4, "oc unlatched", 1'b0, ef_oe);
        cyc(1);
        loc <= 1'b1;
        cyc(1);
        soc <= 1'b0;
        wait_chk(4, "oc latch", 1'b1, ef_oe);
        cyc(1);
        ext_hi <= 1'b1;
        wait_chk(4, "oc clear", 1'b0, ef_oe);
        cyc(1);
        ext_hi <= 1'b0;
        ot_sd <= 1'b1;
        ot_rs <= 1'b1;
        cyc(1);
        ot_sd <= 1'b0;
        wait_chk(4, "ot no hyst", 1'b1, ef_oe);
        cyc(1);
        hyst <= 1'b1;
        wait_chk(4, "ot restart", 1'b0, ef_oe);
        cyc(1);
        ot_rs <= 1'b0;
        hyst <= 1'b0;
    endtask
    task automatic report_and_stop;
        $display("Checks %0d errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        cyc(2);
        rst_n <= 1'b1;
        pwr_done <= 1'b1;
        t_flag();
        wait_frame("ready", 8'h80);
        fault <= 7'h05;
        wait_frame("fault word", 8'h85);
        ls <= 1'b1;
        fault <= 7'h0D;
        wait_chk(7000, "no repeat", 1'b0, st_oe);
        `CHK("no extra", 0, i_mcu.frames.size())
        i_mcu.cmd_low(6400);
        wait_frame("query reply", 8'h0D);
        cyc(6500);
        i_mcu.cmd_low(12800);
        pwr_done <= 1'b0;
        strap <= 2'h2;
        fault <= 7'h00;
        ls <= 1'b0;
        wait_chk(3, "latch reset", 1'b1, pur_seen);
        wait_chk(20, "mission off", 1'b0, st_oe);
        cyc(1);
        pwr_done <= 1'b1;
        wait_frame("ready again", 8'h80);
        `CHK("no drop", 1'b0, drop_seen)
        report_and_stop();
    end
    initial begin
        repeat (100000) @(posedge mclk);
        err_total++;
        report_and_stop();
    end
endmodule // fsb_status_bus_test
